// >>> verilog/tcc_pkg.sv
// Constants and types shared by the 16-bit capture/compare timer.
// How it works
// [R1] Register A capture from input B follows edge bits 00 fall, 01 rise, 11 both.
// [R2] Software never programs edge pair 10 for either timer input.
// [R3] Software loads register A nonzero in clear-on-match mode.
// [R4] A zero compare value matches when the count steps 0000H to 0001H.
// [R5] Compare value below the count waits for wrap through zero before matching.
// [R6] Software ignores capture/compare contents after the timer stops.
// [R7] A register in compare mode does not capture on triggers.
// [R8] The shared pin is either input B source or timer output, never both.
// [R9] Capture wins over a coincident write; the written value is lost.
// [R10] Control bit 2 sets B mode; bit 0 sets A mode, bit 1 A trigger.
// [R11] Reset clears register B; it is written as a full 16-bit word.
// [R12] Register B in compare mode matches the counter every count and requests.
// [R13] Register B capture uses input A edge from prescaler bits 5 and 4.
// [R14] Reset clears the mode control register; byte or bit writes allowed.
// [R15] Counter runs when upper mode bits nonzero; stops cleared when both zero.
// [R16] Mode 01 free-run, 10 clear on input A edge, 11 clear on A match.
// [R17] Output inverts on compare matches; with mode control bit 1 set also A edges.
// [R18] Requests come from matches or capture edges, never while stopped.
// [R19] Mode control bit 0 reads 1 after counter overflow.
// [R20] A capture trigger copies the counter and raises that register's request.
// [R21] Counter increments on the count clock; a read returns the current count.
package tcc_pkg;
	localparam logic [15:0] TCC_ADDR_MODE = 16'hFF60;
	localparam logic [15:0] TCC_ADDR_PRESC = 16'hFF61;
	localparam logic [15:0] TCC_ADDR_CCCTL = 16'hFF62;
	localparam logic [15:0] TCC_ADDR_REGA = 16'hFF12;
	localparam logic [15:0] TCC_ADDR_REGB = 16'hFF14;
	localparam logic [15:0] TCC_ADDR_CNT = 16'hFF16;
	localparam logic [7:0] TCC_RST_BYTE = 8'h00;
	localparam logic [15:0] TCC_RST_WORD = 16'h0000;
	localparam logic [15:0] TCC_CNT_MAX = 16'hFFFF;
	localparam logic [7:0] TCC_MODE_WMASK = 8'h0F;
	localparam logic [7:0] TCC_PRESC_WMASK = 8'hF3;
	localparam logic [7:0] TCC_CCCTL_WMASK = 8'h07;
	localparam int TCC_BIT_OVF = 0;
	localparam int TCC_BIT_INV = 1;
	localparam int TCC_BIT_MODE_LO = 2;
	localparam int TCC_BIT_A_CAP = 0;
	localparam int TCC_BIT_A_SRC = 1;
	localparam int TCC_BIT_B_CAP = 2;
	localparam int TCC_BIT_EDGE_A_LO = 4;
	localparam int TCC_BIT_EDGE_B_LO = 6;
	localparam logic [1:0] TCC_EDGE_FALL = 2'h0;
	localparam logic [1:0] TCC_EDGE_RISE = 2'h1;
	localparam logic [1:0] TCC_EDGE_BOTH = 2'h3;

	typedef enum logic [1:0] {
		TCC_STOP = 2'b00,
		TCC_FREE = 2'b01,
		TCC_CLR_EDGE = 2'b10,
		TCC_CLR_MATCH = 2'b11
	} tcc_mode_t;

	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic wide;
		logic [15:0] wdata;
		logic [7:0] bitMask;
	} tcc_mem_req_t;
endpackage

// >>> verilog/tcc_edge_sel.sv
// Edge detector for one timer input with a two-bit edge selection.
`timescale 1ns/100ps
`default_nettype none
module tcc_edge_sel (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic pinIn,
	input wire logic [1:0] edgeSel,
	output logic rise,
	output logic fall,
	output logic valid
);
	logic prev_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= pinIn;
		end
	end

	assign rise = pinIn & ~prev_q;
	assign fall = ~pinIn & prev_q;
	// Encoding 10 selects no edge at all
	assign valid = (edgeSel == tcc_pkg::TCC_EDGE_FALL) ? fall :
		(edgeSel == tcc_pkg::TCC_EDGE_RISE) ? rise :
		(edgeSel == tcc_pkg::TCC_EDGE_BOTH) ? (rise | fall) : 1'b0;
endmodule
`default_nettype wire

// >>> verilog/tcc_timer16.sv
// 16-bit timer with two capture/compare registers and mode control.
`timescale 1ns/100ps
`default_nettype none
module tcc_timer16 #(
	parameter int CNT_W = 16
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire tcc_pkg::tcc_mem_req_t memReq,
	output logic [15:0] memRdata,
	input wire logic countTick,
	input wire logic timer_input_a,
	input wire logic timer_input_b,
	input wire logic pinSelOut,
	output logic timer_output_pin,
	output logic timerOutOe,
	output logic match_irq_a,
	output logic match_irq_b
);
	logic [7:0] modeCtl_q, modeCtl_d;
	logic [7:0] presc_q, presc_d;
	logic [7:0] ccCtl_q, ccCtl_d;
	logic [CNT_W-1:0] capcmpA_q, capcmpA_d;
	logic [CNT_W-1:0] capcmpB_q, capcmpB_d;
	logic [CNT_W-1:0] upCnt_q, upCnt_d;
	logic [15:0] rdata_q;
	logic outFf_q, oe_q, irqA_q, irqB_q;
	tcc_pkg::tcc_mode_t mode;
	logic running, aRise, aFall, aValid, bValid, bRawValid;
	logic aCapSel, aSrcA, bCapSel, invOnEdge;
	logic aCapTrig, bCapTrig, aMatch, bMatch, cntClear, wrap;
	logic hitMode, hitPresc, hitCcCtl, hitA, hitB;
	logic [7:0] modeMerged, prescMerged, ccMerged;
	logic [15:0] rdMux;

	tcc_edge_sel edgeA (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pinIn(timer_input_a),
		.edgeSel(presc_q[tcc_pkg::TCC_BIT_EDGE_A_LO +: 2]),
		.rise(aRise),
		.fall(aFall),
		.valid(aValid)
	);

	tcc_edge_sel edgeB (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pinIn(timer_input_b),
		.edgeSel(presc_q[tcc_pkg::TCC_BIT_EDGE_B_LO +: 2]),
		.rise(),
		.fall(),
		.valid(bRawValid)
	);

	// [R16] mode pair decode
	assign mode = tcc_pkg::tcc_mode_t'(modeCtl_q[tcc_pkg::TCC_BIT_MODE_LO +: 2]);
	assign running = (mode != tcc_pkg::TCC_STOP);
	// [R10] mode and source bits
	assign aCapSel = ccCtl_q[tcc_pkg::TCC_BIT_A_CAP];
	assign aSrcA = ccCtl_q[tcc_pkg::TCC_BIT_A_SRC];
	assign bCapSel = ccCtl_q[tcc_pkg::TCC_BIT_B_CAP];
	assign invOnEdge = modeCtl_q[tcc_pkg::TCC_BIT_INV];
	// [R8] pin used as output masks input B
	assign bValid = bRawValid & ~pinSelOut;
	// [R1] A from input B; from input A the opposite phase, none for both edges
	assign aCapTrig = running & aCapSel & (aSrcA ?
		((presc_q[tcc_pkg::TCC_BIT_EDGE_A_LO +: 2] == tcc_pkg::TCC_EDGE_FALL) ? aRise :
		(presc_q[tcc_pkg::TCC_BIT_EDGE_A_LO +: 2] == tcc_pkg::TCC_EDGE_RISE) ? aFall : 1'b0)
		: bValid);
	// [R13] B capture on input A valid edge
	assign bCapTrig = running & bCapSel & aValid;
	// [R4] [R5] match on the count leaving the equal value
	assign aMatch = running & countTick & ~aCapSel & (upCnt_q == capcmpA_q);
	// [R12] B compared on every count
	assign bMatch = running & countTick & ~bCapSel & (upCnt_q == capcmpB_q);
	assign wrap = running & countTick & (upCnt_q == tcc_pkg::TCC_CNT_MAX);

	always_comb begin
		case (mode)
			tcc_pkg::TCC_STOP: cntClear = 1'b1;
			tcc_pkg::TCC_FREE: cntClear = 1'b0;
			tcc_pkg::TCC_CLR_EDGE: cntClear = aValid;
			tcc_pkg::TCC_CLR_MATCH: cntClear = aMatch;
			default: cntClear = 1'b1;
		endcase
	end

	// [R15] stop holds zero; [R21] count on tick
	assign upCnt_d = cntClear ? CNT_W'(tcc_pkg::TCC_RST_WORD) :
		(countTick ? upCnt_q + CNT_W'(1) : upCnt_q);

	assign hitMode = (memReq.addr == tcc_pkg::TCC_ADDR_MODE);
	assign hitPresc = (memReq.addr == tcc_pkg::TCC_ADDR_PRESC);
	assign hitCcCtl = (memReq.addr == tcc_pkg::TCC_ADDR_CCCTL);
	assign hitA = (memReq.addr == tcc_pkg::TCC_ADDR_REGA);
	assign hitB = (memReq.addr == tcc_pkg::TCC_ADDR_REGB);

	// [R14] byte and single-bit writes through the bit mask
	assign modeMerged = ((modeCtl_q & ~memReq.bitMask) | (memReq.wdata[7:0] & memReq.bitMask))
		& tcc_pkg::TCC_MODE_WMASK;
	assign prescMerged = ((presc_q & ~memReq.bitMask) | (memReq.wdata[7:0] & memReq.bitMask))
		& tcc_pkg::TCC_PRESC_WMASK;
	assign ccMerged = ((ccCtl_q & ~memReq.bitMask) | (memReq.wdata[7:0] & memReq.bitMask))
		& tcc_pkg::TCC_CCCTL_WMASK;

	always_comb begin
		modeCtl_d = modeCtl_q;
		if (memReq.wr && !memReq.wide && hitMode) begin
			modeCtl_d = modeMerged;
		end
		// [R19] overflow sets, and wins over a clearing write
		if (wrap) begin
			modeCtl_d[tcc_pkg::TCC_BIT_OVF] = 1'b1;
		end
	end

	assign presc_d = (memReq.wr && !memReq.wide && hitPresc) ? prescMerged : presc_q;
	assign ccCtl_d = (memReq.wr && !memReq.wide && hitCcCtl) ? ccMerged : ccCtl_q;

	// [R20] capture copies the count; [R9] capture beats a write
	// [R7] compare mode never captures
	assign capcmpA_d = aCapTrig ? upCnt_q :
		((memReq.wr && memReq.wide && hitA) ? CNT_W'(memReq.wdata) : capcmpA_q);
	// [R11] full-word write only
	assign capcmpB_d = bCapTrig ? upCnt_q :
		((memReq.wr && memReq.wide && hitB) ? CNT_W'(memReq.wdata) : capcmpB_q);

	// Reads of an unmapped address return zero
	always_comb begin
		rdMux = tcc_pkg::TCC_RST_WORD;
		if (hitMode) begin
			rdMux = {8'h00, modeCtl_q};
		end else if (hitPresc) begin
			rdMux = {8'h00, presc_q};
		end else if (hitCcCtl) begin
			rdMux = {8'h00, ccCtl_q};
		end else if (hitA) begin
			rdMux = 16'(capcmpA_q);
		end else if (hitB) begin
			rdMux = 16'(capcmpB_q);
		end else if (memReq.addr == tcc_pkg::TCC_ADDR_CNT) begin
			rdMux = 16'(upCnt_q);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			modeCtl_q <= tcc_pkg::TCC_RST_BYTE;
			presc_q <= tcc_pkg::TCC_RST_BYTE;
			ccCtl_q <= tcc_pkg::TCC_RST_BYTE;
			capcmpA_q <= CNT_W'(tcc_pkg::TCC_RST_WORD);
			capcmpB_q <= CNT_W'(tcc_pkg::TCC_RST_WORD);
			upCnt_q <= CNT_W'(tcc_pkg::TCC_RST_WORD);
		end else begin
			modeCtl_q <= modeCtl_d;
			presc_q <= presc_d;
			ccCtl_q <= ccCtl_d;
			capcmpA_q <= capcmpA_d;
			capcmpB_q <= capcmpB_d;
			upCnt_q <= upCnt_d;
		end
	end

	// Read data holds until the next read strobe
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdata_q <= tcc_pkg::TCC_RST_WORD;
		end else if (memReq.rd) begin
			rdata_q <= rdMux;
		end
	end

	// [R18] requests only while running
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irqA_q <= 1'b0;
			irqB_q <= 1'b0;
		end else begin
			irqA_q <= aMatch | aCapTrig;
			irqB_q <= bMatch | bCapTrig;
		end
	end

	// [R17] inversion on matches, plus input A edges when enabled
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			outFf_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			oe_q <= pinSelOut;
			if (aMatch | bMatch | (running & invOnEdge & aValid)) begin
				outFf_q <= ~outFf_q;
			end
		end
	end

	assign memRdata = rdata_q;
	assign match_irq_a = irqA_q;
	assign match_irq_b = irqB_q;
	assign timer_output_pin = outFf_q;
	// [R8] pin driven only in output use
	assign timerOutOe = oe_q;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	AST_B_EDGE_CAPTURE: assert property (running && aCapSel && !aSrcA && bValid // [R1]
		|=> capcmpA_q == $past(upCnt_q)) else $error("A missed capture on input B edge");
	AST_ZERO_AFTER_WRAP: assert property ((mode == tcc_pkg::TCC_FREE) && !bCapSel // [R4]
		&& capcmpB_q == '0 && countTick && upCnt_q == '0 |=> match_irq_b)
		else $error("Zero compare did not match on step to one");
	AST_WRAP_TO_ZERO: assert property ((mode == tcc_pkg::TCC_FREE) && countTick // [R5]
		&& upCnt_q == tcc_pkg::TCC_CNT_MAX |=> upCnt_q == '0 && modeCtl_q[0])
		else $error("Counter did not wrap to zero with overflow");
	AST_NO_CMP_CAPTURE: assert property (!aCapSel && !(memReq.wr && hitA) // [R7]
		|=> $stable(capcmpA_q)) else $error("Compare register A changed without write");
	AST_PIN_EXCLUSIVE: assert property (pinSelOut && aCapSel && !aSrcA && !(memReq.wr && hitA) // [R8]
		|=> $stable(capcmpA_q) && !match_irq_a) else $error("Input B edge used while pin is output");
	AST_CAPTURE_WINS: assert property (bCapTrig && memReq.wr && memReq.wide && hitB // [R9]
		|=> capcmpB_q == $past(upCnt_q)) else $error("Write beat capture on B");
	AST_B_COMPARE: assert property (running && !bCapSel && countTick // [R12]
		&& upCnt_q == capcmpB_q |=> match_irq_b) else $error("B compare match lost");
	AST_STOP_CLEARS: assert property (mode == tcc_pkg::TCC_STOP |=> upCnt_q == '0) // [R15]
		else $error("Stopped counter not zero");
	AST_NO_IRQ_STOPPED: assert property (!running |=> !match_irq_a && !match_irq_b) // [R18]
		else $error("Request raised while stopped");
	AST_OVF_STICKY: assert property (wrap && memReq.wr && !memReq.wide && hitMode // [R19]
		|=> modeCtl_q[tcc_pkg::TCC_BIT_OVF]) else $error("Overflow flag lost");
	AST_CLEAR_ON_MATCH: assert property ((mode == tcc_pkg::TCC_CLR_MATCH) && aMatch // [R16]
		|=> upCnt_q == '0 && match_irq_a) else $error("Clear on A match failed");
	// Checks look one edge after the cause, at registered state and outputs
	AST_A_REV_RISE: assert property (running && aCapSel && aSrcA && aRise // [R10]
		&& presc_q[tcc_pkg::TCC_BIT_EDGE_A_LO +: 2] == tcc_pkg::TCC_EDGE_FALL
		|=> capcmpA_q == $past(upCnt_q) && match_irq_a) else $error("A missed reverse rise");
	AST_A_REV_FALL: assert property (running && aCapSel && aSrcA && aFall // [R10]
		&& presc_q[tcc_pkg::TCC_BIT_EDGE_A_LO +: 2] == tcc_pkg::TCC_EDGE_RISE
		|=> capcmpA_q == $past(upCnt_q) && match_irq_a) else $error("A missed reverse fall");
	AST_A_REV_BOTH: assert property (running && aCapSel && aSrcA && !(memReq.wr && hitA) // [R10]
		&& presc_q[tcc_pkg::TCC_BIT_EDGE_A_LO +: 2] == tcc_pkg::TCC_EDGE_BOTH
		|=> $stable(capcmpA_q) && !match_irq_a) else $error("A captured on both edges of A");
	AST_B_CAP_A_EDGE: assert property (running && bCapSel && aValid // [R13]
		|=> capcmpB_q == $past(upCnt_q) && match_irq_b)
		else $error("B missed capture on input A edge");
	AST_A_COMPARE: assert property (running && !aCapSel && countTick // [R18]
		&& upCnt_q == capcmpA_q |=> match_irq_a)
		else $error("A compare match lost");
	AST_B_BYTE_IGNORED: assert property (memReq.wr && !memReq.wide && hitB && !bCapTrig // [R11]
		|=> $stable(capcmpB_q))
		else $error("Byte write changed register B");
	AST_B_WORD_WRITE: assert property (memReq.wr && memReq.wide && hitB && !bCapTrig // [R11]
		|=> capcmpB_q == $past(memReq.wdata))
		else $error("Word write to register B lost");
	AST_MODE_WRITE_BITS: assert property (memReq.wr && !memReq.wide && hitMode && !wrap // [R14]
		|=> ((modeCtl_q ^ $past(memReq.wdata[7:0])) & $past(memReq.bitMask)
		& tcc_pkg::TCC_MODE_WMASK) == 8'h00) else $error("Masked mode write not taken");
	AST_MODE_KEEP_BITS: assert property (memReq.wr && !memReq.wide && hitMode && !wrap // [R14]
		|=> ((modeCtl_q ^ $past(modeCtl_q)) & ~$past(memReq.bitMask)) == 8'h00)
		else $error("Unmasked mode bits changed");
	AST_OVF_CLEAR: assert property (memReq.wr && !memReq.wide && hitMode && !wrap // [R19]
		&& memReq.bitMask[tcc_pkg::TCC_BIT_OVF] && !memReq.wdata[tcc_pkg::TCC_BIT_OVF]
		|=> !modeCtl_q[tcc_pkg::TCC_BIT_OVF]) else $error("Overflow flag not cleared");
	AST_OUT_ON_MATCH: assert property (aMatch || bMatch // [R17]
		|=> timer_output_pin != $past(timer_output_pin))
		else $error("Output did not invert on match");
	AST_OUT_EDGE_OFF: assert property (!invOnEdge && !aMatch && !bMatch // [R17]
		|=> $stable(timer_output_pin))
		else $error("Output inverted without cause");
	AST_OUT_EDGE_ON: assert property (running && invOnEdge && aValid // [R17]
		|=> timer_output_pin != $past(timer_output_pin))
		else $error("Output did not invert on input A edge");
	AST_CLEAR_ON_EDGE: assert property ((mode == tcc_pkg::TCC_CLR_EDGE) && aValid // [R16]
		|=> upCnt_q == '0)
		else $error("Clear on input A edge failed");
	AST_COUNT_STEP: assert property (running && countTick && !cntClear // [R21]
		|=> upCnt_q == $past(upCnt_q) + CNT_W'(1))
		else $error("Counter did not step on tick");
	AST_COUNT_HOLD: assert property (running && !countTick && !cntClear // [R21]
		|=> $stable(upCnt_q))
		else $error("Counter moved without tick");
	AST_OE_FOLLOWS: assert property (1'b1 // [R8]
		|=> timerOutOe == $past(pinSelOut))
		else $error("Output enable does not follow pin use");
	AST_COUNT_READ: assert property (memReq.rd && memReq.addr == tcc_pkg::TCC_ADDR_CNT // [R21]
		|=> memRdata == 16'($past(upCnt_q)))
		else $error("Counter read returned wrong value");
	AST_STOP_NO_CAPTURE: assert property (!running && !(memReq.wr && (hitA || hitB)) // [R18]
		|=> $stable(capcmpA_q) && $stable(capcmpB_q))
		else $error("Capture while stopped");

	COV_FREE_WRAP: cover property (wrap);
	COV_CAPTURE_B: cover property (bCapTrig ##1 match_irq_b);
	COV_CLEAR_MATCH: cover property ((mode == tcc_pkg::TCC_CLR_MATCH) && aMatch);
	COV_TOGGLE_EDGE: cover property (running && invOnEdge && aValid);
	COV_EDGE_CLEAR: cover property ((mode == tcc_pkg::TCC_CLR_EDGE) && aValid);
endmodule
`default_nettype wire

// >>> verif/tcc_pulse_src.sv
// Pulse source that stands in for the external timer input drivers.
`timescale 1ns/100ps
`default_nettype none
module tcc_pulse_src (
	input wire logic core_clk,
	output logic pinA,
	output logic pinB
);
	initial begin
		pinA = 1'b0;
		pinB = 1'b0;
	end
	// Each level held past two cycles so both edges are clean
	task automatic pulse(input logic useB);
		repeat (2) begin
			@(negedge core_clk);
			if (useB) pinB = ~pinB;
			else pinA = ~pinA;
			repeat (2) @(negedge core_clk);
		end
	endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the capture/compare timer.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	tcc_pkg::tcc_mem_req_t memReq = '0;
	logic countTick = 1'b0;
	logic pinSelOut = 1'b0;
	logic [15:0] memRdata;
	logic pinA, pinB, outPin, outOe, irqA, irqB;
	logic [15:0] expQ[$];
	logic [31:0] seed = 32'hF723;
	int num_errors = 0;
	int checks_done = 0;
	int irqACnt = 0;
	int irqBCnt = 0;
	always #4 core_clk = ~core_clk;
	tcc_timer16 i_dut (.core_clk(core_clk), .rst_n(rst_n), .memReq(memReq),
		.memRdata(memRdata), .countTick(countTick), .timer_input_a(pinA),
		.timer_input_b(pinB), .pinSelOut(pinSelOut), .timer_output_pin(outPin),
		.timerOutOe(outOe), .match_irq_a(irqA), .match_irq_b(irqB));
	tcc_pulse_src i_src (.core_clk(core_clk), .pinA(pinA), .pinB(pinB));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks=%0d errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Word access for the 16-bit places, byte with full mask otherwise
	task automatic access(input logic [15:0] a, input logic w, input logic [15:0] v);
		@(negedge core_clk);
		memReq = '{a, w, !w, a[7:4] == 4'h1, v, 8'hFF};
		if (!w) expQ.push_back(v);
		@(negedge core_clk);
		memReq = '0;
	endtask
	task automatic ticks(input int n);
		@(negedge core_clk);
		countTick = 1'b1;
		repeat (n) @(negedge core_clk);
		countTick = 1'b0;
	endtask
	// Sampled just after the edge, when read data and pulses have landed
	always @(posedge core_clk) begin
		#1;
		if (irqA === 1'b1) irqACnt++;
		if (irqB === 1'b1) irqBCnt++;
		if (memReq.rd === 1'b1) check(memRdata, expQ.pop_front());
	end
	initial begin
		#700000;
		num_errors++;
		close_out();
	end
	initial begin
		int k;
		int a0;
		int b0;
		logic useB;
		logic [1:0] sel;
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		rst_n = 1'b1;
		access(16'hFF60, 0, 16'h0000);
		access(16'hFF14, 0, 16'h0000);
		access(16'hFF62, 0, 16'h0000);
		access(16'hFF70, 0, 16'h0000);
		seed = lfsr(seed);
		k = int'(seed[5:0]) + 1;
		access(16'hFF60, 1, 16'h0004);
		ticks(k);
		access(16'hFF16, 0, 16'(k));
		access(16'hFF60, 1, 16'h0000);
		access(16'hFF16, 0, 16'h0000);
		$display("reset and count test done");
		access(16'hFF14, 1, 16'h0003);
		access(16'hFF60, 1, 16'h0004);
		b0 = irqBCnt;
		ticks(3);
		check(16'(irqBCnt - b0), 16'h0000);
		// Taken after the zero match of register A has already inverted the pin
		useB = outPin;
		ticks(1);
		check(16'(irqBCnt - b0), 16'h0001);
		check({15'h0000, outPin}, {15'h0000, !useB});
		access(16'hFF60, 1, 16'h0000);
		access(16'hFF14, 1, 16'h0000);
		access(16'hFF60, 1, 16'h0004);
		ticks(65535);
		access(16'hFF16, 0, 16'hFFFF);
		access(16'hFF60, 0, 16'h0004);
		ticks(1);
		access(16'hFF60, 0, 16'h0005);
		b0 = irqBCnt;
		ticks(1);
		check(16'(irqBCnt - b0), 16'h0001);
		access(16'hFF60, 1, 16'h0004);
		access(16'hFF60, 0, 16'h0004);
		access(16'hFF60, 1, 16'h0000);
		b0 = irqBCnt;
		ticks(3);
		check(16'(irqBCnt - b0), 16'h0000);
		access(16'hFF16, 0, 16'h0000);
		$display("compare and overflow test done");
		for (int i = 0; i < 7; i++) begin
			useB = i > 2;
			sel = {i % 3 == 2, i % 3 != 0};
			pinSelOut = i == 6;
			access(16'hFF60, 1, 16'h0000);
			access(16'hFF62, 1, useB ? 16'h0001 : 16'h0004);
			access(16'hFF61, 1, useB ? {8'h00, sel, 6'h00} : {10'h000, sel, 4'h0});
			access(16'hFF60, 1, 16'h0004);
			seed = lfsr(seed);
			k = int'(seed[3:0]) + 1;
			ticks(k);
			a0 = irqACnt;
			b0 = irqBCnt;
			i_src.pulse(useB);
			a0 = useB ? irqACnt - a0 : irqBCnt - b0;
			check(16'(a0), i == 6 ? 16'h0000 : sel == 2'h3 ? 16'h0002 : 16'h0001);
			// read back before the next stop
			if (i < 6) access(useB ? 16'hFF12 : 16'hFF14, 0, 16'(k));
		end
		check({15'h0000, outOe}, 16'h0001);
		pinSelOut = 1'b0;
		$display("capture test done");
		access(16'hFF60, 1, 16'h0000);
		access(16'hFF62, 1, 16'h0000);
		// nonzero compare value for clear on match
		access(16'hFF12, 1, 16'h0005);
		access(16'hFF60, 1, 16'h000C);
		a0 = irqACnt;
		ticks(6);
		check(16'(irqACnt - a0), 16'h0001);
		access(16'hFF16, 0, 16'h0000);
		access(16'hFF60, 1, 16'h0000);
		access(16'hFF61, 1, 16'h0000);
		access(16'hFF60, 1, 16'h0008);
		ticks(4);
		i_src.pulse(1'b0);
		access(16'hFF16, 0, 16'h0000);
		$display("clear mode test done");
		access(16'hFF60, 1, 16'h0000);
		access(16'hFF62, 1, 16'h0003);
		access(16'hFF61, 1, 16'h0010);
		access(16'hFF60, 1, 16'h0004);
		seed = lfsr(seed);
		k = int'(seed[3:0]) + 1;
		ticks(k);
		a0 = irqACnt;
		i_src.pulse(1'b0);
		check(16'(irqACnt - a0), 16'h0001);
		access(16'hFF12, 0, 16'(k));
		access(16'hFF60, 1, 16'h0000);
		access(16'hFF62, 1, 16'h0000);
		access(16'hFF61, 1, 16'h0000);
		access(16'hFF60, 1, 16'h0006);
		access(16'hFF60, 0, 16'h0006);
		useB = outPin;
		i_src.pulse(1'b0);
		check({15'h0000, outPin}, {15'h0000, !useB});
		$display("source and inversion test done");
		close_out();
	end
endmodule
`default_nettype wire
